/* isl_consts.svh */
// Offsets, field positions, reset values and bit counts for the I2C slave.
// Assumes byte addresses on a 32-bit APB bus, one register per word.
`ifndef ISL_CONSTS_SVH
`define ISL_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ISL_OFF_CTRL 8'h00
`define ISL_OFF_STAT 8'h04
`define ISL_OFF_RXB 8'h08
`define ISL_OFF_TXB 8'h0C
`define ISL_OFF_SADDR 8'h10

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define ISL_CTRL_EN 0
`define ISL_CTRL_A10 1
`define ISL_CTRL_RECEIVE_STRETCH_ENABLE 2
`define ISL_CTRL_REL 3

// ----------------------------------------------------------------
// Status register fields (bits 5:0 read-only)
// ----------------------------------------------------------------
`define ISL_ST_RBF 0
`define ISL_ST_TBF 1
`define ISL_ST_RW 2
`define ISL_ST_TEN 3
`define ISL_ST_HOLD 4
`define ISL_ST_BUSY 5
`define ISL_ST_OV 6
`define ISL_ST_EVT 7

// ----------------------------------------------------------------
// Reset values, 10-bit address header and bit counts
// ----------------------------------------------------------------
`define ISL_RST_SADDR 10'h000
`define ISL_RST_REL 1'b1
`define ISL_TEN_HI 5'h1E
`define ISL_BIT_ACK 4'h8
`define ISL_BIT_END 4'h9

`endif

/* isl_pkg.sv */
// Types for the I2C slave: link states and the module's state record.
// Assumes isl_consts.svh supplies all numeric constants.
package isl_pkg;

	// ----------------------------------------------------------------
	// Link states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR2,
		ST_RX,
		ST_TX
	} isl_link_type;

	// ----------------------------------------------------------------
	// Whole state of the slave
	// ----------------------------------------------------------------
	typedef struct packed {
		isl_link_type st;
		logic [3:0] cnt;
		logic [7:0] sr;
		logic [7:0] rxbuf;
		logic [7:0] txbuf;
		logic [9:0] addr;
		logic en;
		logic a10;
		logic receive_stretch_enable;
		logic rel;
		logic receive_full_flag;
		logic transmit_full_flag;
		logic ov;
		logic evt;
		logic rw;
		logic ten;
		logic need_load;
		logic mack;
		logic scl_m;
		logic scl_s;
		logic scl_d;
		logic sda_m;
		logic sda_s;
		logic sda_d;
		logic scl_oe;
		logic sda_oe;
		logic pin_lvl;
		logic evt_pulse;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} isl_state_type;

endpackage : isl_pkg

/* isl_i2c_slave.sv */
// I2C slave with 7/10-bit address match, double-buffered receive,
// transmit register and clock stretching; registers over APB.
// Assumes open-drain SCL/SDA resolved outside, async and slow vs core.
`include "isl_consts.svh"

module isl_i2c_slave (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_scl,
	output logic o_scl,
	output logic o_scl_oe,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	output logic o_slave_event
);

	isl_pkg::isl_state_type r;
	isl_pkg::isl_state_type n;
	logic scl_rise, scl_fall;
	logic start_c, stop_c, apb_acc;

	// ----------------------------------------------------------------
	// Pin edge and bus condition detection
	// ----------------------------------------------------------------
	assign scl_rise = r.scl_s & ~r.scl_d;
	assign scl_fall = ~r.scl_s & r.scl_d;
	// Start/Stop need SCL high on both samples to reject glitches
	assign start_c = r.scl_s & r.scl_d & ~r.sda_s & r.sda_d;
	assign stop_c = r.scl_s & r.scl_d & r.sda_s & ~r.sda_d;
	assign apb_acc = i_psel & i_penable & r.pready;

	function automatic logic [31:0] rd_word(
		input isl_pkg::isl_state_type s,
		input logic [7:0] a
	);
		logic [31:0] w;
		w = 32'h0000_0000;
		unique case (a)
			`ISL_OFF_CTRL: begin
				w[`ISL_CTRL_EN] = s.en;
				w[`ISL_CTRL_A10] = s.a10;
				w[`ISL_CTRL_RECEIVE_STRETCH_ENABLE] = s.receive_stretch_enable;
				w[`ISL_CTRL_REL] = s.rel;
			end
			`ISL_OFF_STAT: begin
				w[`ISL_ST_RBF] = s.receive_full_flag;
				w[`ISL_ST_TBF] = s.transmit_full_flag;
				w[`ISL_ST_RW] = s.rw;
				w[`ISL_ST_TEN] = s.ten;
				w[`ISL_ST_HOLD] = s.scl_oe;
				w[`ISL_ST_BUSY] = s.st != isl_pkg::ST_IDLE;
				w[`ISL_ST_OV] = s.ov;
				w[`ISL_ST_EVT] = s.evt;
			end
			`ISL_OFF_RXB: w[7:0] = s.rxbuf;
			`ISL_OFF_TXB: w[7:0] = s.txbuf;
			`ISL_OFF_SADDR: w[9:0] = s.addr;
			default: w = 32'h0000_0000;
		endcase
		return w;
	endfunction : rd_word

	always_comb begin
		logic hi_ok, tx_start, tx_wr;
		n = r;
		hi_ok = 1'b0;
		tx_start = 1'b0;
		tx_wr = 1'b0;
		n.pready = 1'b0;
		n.evt_pulse = 1'b0;
		n.scl_m = i_scl;
		n.scl_s = r.scl_m;
		n.scl_d = r.scl_s;
		n.sda_m = i_sda;
		n.sda_s = r.sda_m;
		n.sda_d = r.sda_s;
		// ------------------------------------------------------------
		// APB slave: one wait state, answer from registers
		// ------------------------------------------------------------
		if (i_psel && i_penable && !r.pready) begin
			n.pready = 1'b1;
			n.prdata = rd_word(r, i_paddr);
			n.pslverr = !(i_paddr == `ISL_OFF_CTRL ||
				i_paddr == `ISL_OFF_STAT || i_paddr == `ISL_OFF_RXB ||
				i_paddr == `ISL_OFF_TXB || i_paddr == `ISL_OFF_SADDR);
		end
		if (apb_acc && i_pwrite) begin
			unique case (i_paddr)
				`ISL_OFF_CTRL: begin
					n.en = i_pwdata[`ISL_CTRL_EN];
					n.a10 = i_pwdata[`ISL_CTRL_A10];
					n.receive_stretch_enable = i_pwdata[`ISL_CTRL_RECEIVE_STRETCH_ENABLE];
					if (i_pwdata[`ISL_CTRL_REL]) begin
						if (r.receive_stretch_enable || r.need_load)
							n.rel = 1'b1;
					end else if (r.receive_stretch_enable) begin
						n.rel = 1'b0;
					end
				end
				`ISL_OFF_STAT: begin
					n.ov = i_pwdata[`ISL_ST_OV];
					n.evt = i_pwdata[`ISL_ST_EVT];
				end
				`ISL_OFF_TXB: begin
					n.txbuf = i_pwdata[7:0];
					n.transmit_full_flag = 1'b1;
					tx_wr = 1'b1;
				end
				`ISL_OFF_SADDR: n.addr = i_pwdata[9:0];
				default: ;
			endcase
		end
		if (apb_acc && !i_pwrite && i_paddr == `ISL_OFF_RXB)
			n.receive_full_flag = 1'b0;
		// ------------------------------------------------------------
		// Link sequencer; hardware sets override software clears
		// ------------------------------------------------------------
		if (!r.en) begin
			n.st = isl_pkg::ST_IDLE;
			n.sda_oe = 1'b0;
			n.cnt = 4'h0;
			n.need_load = 1'b0;
		end else if (start_c) begin
			n.st = isl_pkg::ST_ADDR;
			n.cnt = 4'h0;
			n.sda_oe = 1'b0;
			n.need_load = 1'b0;
		end else if (stop_c) begin
			n.st = isl_pkg::ST_IDLE;
			n.sda_oe = 1'b0;
			n.need_load = 1'b0;
		end else if (scl_rise && r.st != isl_pkg::ST_IDLE) begin
			if (r.cnt < `ISL_BIT_ACK && r.st != isl_pkg::ST_TX)
				n.sr = {r.sr[6:0], r.sda_s};
			if (r.cnt == `ISL_BIT_ACK && r.st == isl_pkg::ST_TX)
				n.mack = ~r.sda_s;
			n.cnt = r.cnt + 4'h1;
		end else if (scl_fall && r.st != isl_pkg::ST_IDLE) begin
			if (r.cnt == `ISL_BIT_ACK) begin
				n.sda_oe = 1'b0;
				unique case (r.st)
					isl_pkg::ST_ADDR: begin
						hi_ok = r.sr[7:3] == `ISL_TEN_HI &&
							r.sr[2:1] == r.addr[9:8];
						if (!r.a10) begin
							if (r.sr[7:1] == r.addr[6:0]) begin
								n.sda_oe = 1'b1;
								n.rw = r.sr[0];
							end else begin
								n.st = isl_pkg::ST_IDLE;
							end
						end else if (hi_ok && (!r.sr[0] || r.ten)) begin
							n.sda_oe = 1'b1;
							n.rw = r.sr[0];
							if (!r.sr[0])
								n.ten = 1'b0;
						end else begin
							n.ten = 1'b0;
							n.st = isl_pkg::ST_IDLE;
						end
					end
					isl_pkg::ST_ADDR2: begin
						if (r.sr == r.addr[7:0]) begin
							n.sda_oe = 1'b1;
						end else begin
							n.ten = 1'b0;
							n.st = isl_pkg::ST_IDLE;
						end
					end
					isl_pkg::ST_RX: begin
						if (r.receive_full_flag) begin
							n.ov = 1'b1;
						end else begin
							n.rxbuf = r.sr;
							n.receive_full_flag = 1'b1;
							n.sda_oe = ~r.ov;
						end
					end
					default: ;
				endcase
			end else if (r.cnt == `ISL_BIT_END) begin
				n.sda_oe = 1'b0;
				n.cnt = 4'h0;
				n.evt = 1'b1;
				n.evt_pulse = 1'b1;
				unique case (r.st)
					isl_pkg::ST_ADDR: begin
						if (r.rw) begin
							n.st = isl_pkg::ST_TX;
							tx_start = 1'b1;
						end else if (r.a10) begin
							n.st = isl_pkg::ST_ADDR2;
						end else begin
							n.st = isl_pkg::ST_RX;
						end
					end
					isl_pkg::ST_ADDR2: begin
						n.ten = 1'b1;
						n.st = isl_pkg::ST_RX;
					end
					isl_pkg::ST_RX: begin
						if (r.receive_stretch_enable && n.receive_full_flag)
							n.rel = 1'b0;
					end
					isl_pkg::ST_TX: begin
						if (r.mack)
							tx_start = 1'b1;
						else
							n.st = isl_pkg::ST_IDLE;
					end
					default: n.st = isl_pkg::ST_IDLE;
				endcase
			end else if (r.st == isl_pkg::ST_TX && !r.need_load) begin
				n.sr = {r.sr[6:0], 1'b0};
				n.sda_oe = ~r.sr[6];
			end
		end
		// ------------------------------------------------------------
		// Transmit load and stretch
		// ------------------------------------------------------------
		if (tx_start) begin
			if (r.transmit_full_flag) begin
				n.sr = r.txbuf;
				n.sda_oe = ~r.txbuf[7];
				n.transmit_full_flag = tx_wr;
			end else begin
				n.rel = 1'b0;
				n.need_load = 1'b1;
			end
		end else if (r.need_load && r.rel && r.en) begin
			n.sr = r.txbuf;
			n.sda_oe = ~r.txbuf[7];
			n.transmit_full_flag = tx_wr;
			n.need_load = 1'b0;
		end
		// Hold once SCL seen low; one cycle past a load so SDA leads SCL
		n.scl_oe = (~n.rel | r.need_load) & r.en &
			(r.scl_oe | ~r.scl_s);
		n.pin_lvl = 1'b0;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= '0;
			r.st <= isl_pkg::ST_IDLE;
			r.addr <= `ISL_RST_SADDR;
			r.rel <= `ISL_RST_REL;
			r.scl_m <= 1'b1;
			r.scl_s <= 1'b1;
			r.scl_d <= 1'b1;
			r.sda_m <= 1'b1;
			r.sda_s <= 1'b1;
			r.sda_d <= 1'b1;
		end else if (i_clk_en) begin
			r <= n;
		end
	end

	assign o_prdata = r.prdata;
	assign o_pready = r.pready;
	assign o_pslverr = r.pslverr;
	assign o_scl = r.pin_lvl;
	assign o_scl_oe = r.scl_oe;
	assign o_sda = r.pin_lvl;
	assign o_sda_oe = r.sda_oe;
	assign o_slave_event = r.evt_pulse;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_slot_ack(isl_pkg::isl_link_type s);
		r.st == s && scl_fall && r.cnt == `ISL_BIT_ACK && r.en &&
			!start_c && !stop_c;
	endsequence
	sequence s_slot_end(isl_pkg::isl_link_type s);
		r.st == s && scl_fall && r.cnt == `ISL_BIT_END && r.en &&
			!start_c && !stop_c;
	endsequence
	property p_idle_off;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		!r.en && i_clk_en |=> r.st == isl_pkg::ST_IDLE && !o_sda_oe;
	endproperty
	a_idle_off: assert property (p_idle_off)
		else $error("slave not idle while disabled");
	property p_event_fall;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		$rose(o_slave_event) |-> $past(scl_fall) && r.evt;
	endproperty
	a_event_fall: assert property (p_event_fall)
		else $error("event pulse without ninth falling edge");
	property p_addr_keeps_rx;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		s_slot_ack(isl_pkg::ST_ADDR) ##0 i_clk_en |=>
			$stable(r.rxbuf) ##1 $stable(r.rxbuf);
	endproperty
	a_addr_keeps_rx: assert property (p_addr_keeps_rx)
		else $error("address byte changed receive buffer");
	property p_rx_ack;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		s_slot_ack(isl_pkg::ST_RX) ##0 (!r.receive_full_flag && !r.ov && i_clk_en) |=>
			o_sda_oe && r.receive_full_flag && r.rxbuf == $past(r.sr);
	endproperty
	a_rx_ack: assert property (p_rx_ack)
		else $error("received byte not stored or not acked");
	property p_rx_full;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		s_slot_ack(isl_pkg::ST_RX) ##0 (r.receive_full_flag && i_clk_en) |=>
			!o_sda_oe && $stable(r.rxbuf) && r.ov;
	endproperty
	a_rx_full: assert property (p_rx_full)
		else $error("full buffer overwritten or acked");
	property p_rx_ov;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		s_slot_ack(isl_pkg::ST_RX) ##0 (!r.receive_full_flag && r.ov && i_clk_en) |=>
			!o_sda_oe && r.rxbuf == $past(r.sr);
	endproperty
	a_rx_ov: assert property (p_rx_ov)
		else $error("overflow case not loaded with nack");
	property p_tx_stretch;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		s_slot_end(isl_pkg::ST_TX) ##0 (r.mack && !r.transmit_full_flag && i_clk_en) |=>
			!r.rel ##1 (o_scl_oe || r.scl_s);
	endproperty
	a_tx_stretch: assert property (p_tx_stretch)
		else $error("empty transmit did not stretch");
	property p_tx_nostretch;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		s_slot_end(isl_pkg::ST_TX) ##0 (r.mack && r.transmit_full_flag && r.rel &&
			i_clk_en) |=> r.rel && !r.need_load;
	endproperty
	a_tx_nostretch: assert property (p_tx_nostretch)
		else $error("preloaded transmit stretched");
	property p_rel_ignored;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		apb_acc && i_pwrite && i_paddr == `ISL_OFF_CTRL && !r.receive_stretch_enable &&
			!r.need_load && i_clk_en |=> $stable(r.rel);
	endproperty
	a_rel_ignored: assert property (p_rel_ignored)
		else $error("release write taken with stretch disabled");
endmodule : isl_i2c_slave

/* isl_i2c_master.sv */
// Behavioural I2C bus master facing the slave.
// Assumes the bench resolves open-drain wires with pull-ups.
module isl_i2c_master (
	input wire logic i_core_clk,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_scl_oe,
	output logic o_sda_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		o_scl_oe = 1'b0;
		o_sda_oe = 1'b0;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask : wt

	// Waits out a slave stretch; no fixed high time
	task automatic rise();
		o_scl_oe <= 1'b0;
		do
			@(posedge i_core_clk);
		while (i_scl !== 1'b1);
	endtask : rise

	// Also a repeated start; extra wait lets the slave drop SDA
	task automatic start();
		wt(2);
		o_sda_oe <= 1'b0;
		wt(4);
		rise();
		wt(4);
		o_sda_oe <= 1'b1;
		wt(4);
		o_scl_oe <= 1'b1;
	endtask : start

	task automatic stop();
		wt(2);
		o_sda_oe <= 1'b1;
		wt(4);
		rise();
		wt(4);
		o_sda_oe <= 1'b0;
		wt(4);
	endtask : stop

	task automatic bit_io(input logic b, output logic r);
		wt(2);
		o_sda_oe <= ~b;
		wt(2);
		rise();
		wt(2);
		r = i_sda;
		wt(1);
		o_scl_oe <= 1'b1;
	endtask : bit_io

	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		// Let the ninth-fall event land before the caller looks
		wt(6);
		ack = ~r;
	endtask : wr_byte

	task automatic rd_byte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(~ack, r);
		wt(6);
	endtask : rd_byte
endmodule : isl_i2c_master

/* isl_i2c_slave_tb.sv */
// Self-checking bench for the I2C slave: APB registers and bus traffic.
// Assumes a 40 MHz core clock and the master model beside it.
`include "isl_consts.svh"
module isl_i2c_slave_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] a_ct = `ISL_OFF_CTRL;
	localparam logic [7:0] a_st = `ISL_OFF_STAT;
	localparam logic [7:0] a_rx = `ISL_OFF_RXB;
	localparam logic [7:0] a_tx = `ISL_OFF_TXB;
	localparam logic [7:0] a_ad = `ISL_OFF_SADDR;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, ack;
	logic s_scl, s_scl_oe, s_sda, s_sda_oe, evt, m_scl_oe, m_sda_oe;
	logic [7:0] paddr, d;
	logic [31:0] pwdata, prdata, rd;
	int fail_count = 0;
	int tests_run = 0;
	int ev_cnt = 0;
	int hold_cnt = 0;
	int cyc = 0;
	wire logic scl = !((s_scl_oe && !s_scl) || m_scl_oe);
	wire logic sda = !((s_sda_oe && !s_sda) || m_sda_oe);

	isl_i2c_slave dut_u (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_scl(scl),
		.o_scl(s_scl), .o_scl_oe(s_scl_oe), .i_sda(sda),
		.o_sda(s_sda), .o_sda_oe(s_sda_oe), .o_slave_event(evt));
	isl_i2c_master mst_u (.i_core_clk(clk), .i_scl(scl), .i_sda(sda),
		.o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Hang guard well above the few thousand cycles needed
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (evt === 1'b1)
			ev_cnt <= ev_cnt + 1;
		if (s_scl_oe === 1'b1)
			hold_cnt <= hold_cnt + 1;
		if (cyc == 20000) begin
			fail_count = fail_count + 1;
			end_sim();
		end
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// Waits for pready with no timeout of its own; only the hang guard ends a wait that never sees it
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdc

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	// ----
	// Scenarios
	// ----
	task automatic t_regs();
		rdc(a_ct, 32'h8);
		rdc(a_st, 32'h0);
		rdc(a_ad, 32'h0);
		apb(1'b1, a_ad, 32'h3FF);
		rdc(a_ad, 32'h3FF);
		apb(1'b1, a_ct, 32'hF);
		rdc(a_ct, 32'hF);
		apb(1'b1, a_ct, 32'hB);
		rdc(a_ct, 32'hB);
		apb(1'b1, a_ct, 32'h1);
		rdc(a_ct, 32'h9);
		apb(1'b1, a_st, 32'h3F);
		rdc(a_st, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk({err, rd}, 33'h100000000);
	endtask : t_regs

	task automatic t_write();
		int e;
		apb(1'b1, a_ad, 32'h55);
		apb(1'b1, a_ct, 32'h8);
		mst_u.start();
		mst_u.wr_byte(8'hAA, ack);
		chk(ack, 0);
		apb(1'b1, a_ct, 32'h9);
		e = ev_cnt;
		mst_u.start();
		mst_u.wr_byte(8'hAC, ack);
		chk({ack, ev_cnt}, {1'b0, e});
		mst_u.start();
		mst_u.wr_byte(8'hAA, ack);
		chk({ack, ev_cnt}, {1'b1, e + 1});
		apb(1'b0, a_st, 32'h0);
		chk(rd[0], 0);
		mst_u.wr_byte(8'hA3, ack);
		chk({ack, ev_cnt}, {1'b1, e + 2});
		rdc(a_rx, 32'hA3);
	endtask : t_write

	task automatic t_ovf();
		int e;
		mst_u.wr_byte(8'h11, ack);
		chk(ack, 1);
		e = ev_cnt;
		mst_u.wr_byte(8'h22, ack);
		chk({ack, ev_cnt}, {1'b0, e + 1});
		apb(1'b0, a_st, 32'h0);
		chk({rd[6], rd[0]}, 2'b11);
		rdc(a_rx, 32'h11);
		mst_u.wr_byte(8'h33, ack);
		chk(ack, 0);
		rdc(a_rx, 32'h33);
		apb(1'b1, a_st, 32'h0);
		mst_u.stop();
	endtask : t_ovf

	task automatic t_rx_stretch();
		apb(1'b1, a_ct, 32'hD);
		mst_u.start();
		mst_u.wr_byte(8'hAA, ack);
		mst_u.wr_byte(8'h44, ack);
		chk(ack, 1);
		fork
			mst_u.wr_byte(8'h66, ack);
			begin
				repeat (40) @(posedge clk);
				chk(scl, 0);
				rdc(a_ct, 32'h5);
				rdc(a_rx, 32'h44);
				apb(1'b1, a_ct, 32'hD);
			end
		join
		chk(ack, 1);
		rdc(a_rx, 32'h66);
		apb(1'b1, a_ct, 32'hD);
		mst_u.stop();
	endtask : t_rx_stretch

	// Stretch-enable off: transmit must still stretch
	task automatic t_read();
		int e, h;
		apb(1'b1, a_ct, 32'h9);
		mst_u.start();
		mst_u.wr_byte(8'hAB, ack);
		chk(ack, 1);
		fork
			mst_u.rd_byte(1'b1, d);
			begin
				repeat (40) @(posedge clk);
				chk(scl, 0);
				apb(1'b0, a_st, 32'h0);
				chk(rd[2], 1);
				apb(1'b1, a_tx, 32'hC5);
				apb(1'b1, a_ct, 32'h9);
				apb(1'b1, a_tx, 32'h3A);
			end
		join
		chk(d, 8'hC5);
		e = ev_cnt;
		h = hold_cnt;
		mst_u.rd_byte(1'b0, d);
		chk(d, 8'h3A);
		chk({hold_cnt, ev_cnt}, {h, e + 1});
		mst_u.stop();
	endtask : t_read

	task automatic t_ten();
		int e;
		apb(1'b1, a_ad, 32'h2A5);
		apb(1'b1, a_ct, 32'h3);
		e = ev_cnt;
		mst_u.start();
		mst_u.wr_byte(8'hF4, ack);
		chk({ack, ev_cnt}, {1'b1, e + 1});
		apb(1'b0, a_st, 32'h0);
		chk(rd[3], 0);
		mst_u.wr_byte(8'hA5, ack);
		chk({ack, ev_cnt}, {1'b1, e + 2});
		apb(1'b0, a_st, 32'h0);
		chk(rd[3], 1);
		mst_u.start();
		mst_u.wr_byte(8'hF5, ack);
		chk(ack, 1);
		fork
			mst_u.rd_byte(1'b0, d);
			begin
				repeat (40) @(posedge clk);
				chk(scl, 0);
				apb(1'b1, a_tx, 32'h5C);
				apb(1'b1, a_ct, 32'hB);
			end
		join
		chk(d, 8'h5C);
		mst_u.stop();
		mst_u.start();
		mst_u.wr_byte(8'hF6, ack);
		chk(ack, 0);
		mst_u.stop();
	endtask : t_ten

	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_regs();
		t_write();
		t_ovf();
		t_rx_stretch();
		t_read();
		t_ten();
		end_sim();
	end
endmodule : isl_i2c_slave_tb
